// ### adc_mode_pkg.sv
/*
 * Shared constants for the converter mode controller: word layout,
 * serial command codes, postfilter settling times and cycle counts.
 * Assumes a 50 MHz master clock; times are converted to cycles here.
 */
package adc_mode_pkg;

	// channels and word layout
	localparam int CHAN_NUM = 16;
	localparam int CHAN_W = 4;
	localparam int SAMPLE_W = 24;
	localparam int STATUS_W = 8;
	localparam int WORD_W = 32;
	localparam int BITCNT_W = 6;
	localparam logic [BITCNT_W-1:0] LEN_PLAIN = 6'h18;
	localparam logic [BITCNT_W-1:0] LEN_STATUS = 6'h20;
	localparam logic [BITCNT_W-1:0] CMD_LAST_BIT = 6'h07;
	localparam int STAT_RDY_BIT = 7;
	localparam logic [CHAN_W-1:0] RST_CHAN = 4'h0;

	// serial commands and reset sequence
	localparam logic [7:0] CMD_READ_DATA = 8'h44;
	localparam int ONES_W = 7;
	localparam logic [ONES_W-1:0] RESET_ONES_LAST = 7'h3F;

	// filter selection encodings
	localparam logic FILT_SINC5_SINC1 = 1'b0;
	localparam logic [1:0] ENH_27SPS = 2'h0;
	localparam logic [1:0] ENH_25SPS = 2'h1;
	localparam logic [1:0] ENH_20SPS = 2'h2;
	localparam logic [1:0] ENH_16SPS = 2'h3;

	// timing: settling times per enhanced setting, base conversion time
	localparam real CLK_MHZ = 50.0;
	localparam real SETTLE_27_MS = 36.67;
	localparam real SETTLE_25_MS = 40.0;
	localparam real SETTLE_20_MS = 50.0;
	localparam real SETTLE_16_MS = 60.0;
	localparam real BASE_CONV_US = 200.0;
	localparam int SETTLE_27_CYC = int'($floor(SETTLE_27_MS * 1000.0 * CLK_MHZ));
	localparam int SETTLE_25_CYC = int'($floor(SETTLE_25_MS * 1000.0 * CLK_MHZ));
	localparam int SETTLE_20_CYC = int'($floor(SETTLE_20_MS * 1000.0 * CLK_MHZ));
	localparam int SETTLE_16_CYC = int'($floor(SETTLE_16_MS * 1000.0 * CLK_MHZ));
	localparam int BASE_CONV_CYC = int'($floor(BASE_CONV_US * CLK_MHZ));
	localparam int CONV_CNT_W = 24;
	localparam int PRE_LOAD_CYC = 1;

	typedef enum logic [1:0] {PH_CMD, PH_DATA, PH_DONE} phase_type;

endpackage

// ### adc_conversion_mode_control.sv
/*
 * Conversion and readout mode control: continuous conversion with channel
 * sequencing, ready signalling, overrun handling, status append, and the
 * streaming read mode driven straight by serial clocks.
 * Assumes the modulator presents sample_in on the master clock, and the
 * serial host clocks sclk_in while chip select is low, apart from idle clocks at reset.
 */
// Behaviour
// R1: enhanced 50/60 Hz settings, fastest rate 27.27 samples per second.
// R2: slowest enhanced setting gives best rejection near 50 and 60 Hz.
// R3: enhanced postfilter only valid with sinc5 plus sinc1 selected.
// R4: after reset the converter runs continuous conversions unprompted.
// R5: each completed conversion clears the active-low ready status bit.
// R6: completion drives data-out/ready low only while chip select low.
// R7: host writes read command, then clocks out the conversion word.
// R8: after a word read the output rises; rereading stays allowed.
// R9: a conversion completing during a data read is discarded.
// R10: enabled channels convert lowest to highest, then wrap around.
// R11: data updates at each completion and ready pulses low.
// R12: status append shifts status, with channel, after the data.
// R13: in streaming read the host just clocks bits after ready falls.
// R14: streaming read word is readable once; ready stays high after.
// R15: unread streaming word is cleared just before the new result loads.
// R16: host enables streaming read only in continuous conversion.
// R17: setting stream read enable enters streaming read mode.
// R18: read command while ready low leaves streaming read mode.
// R19: 64 clocks with data input high reset everything, any mode.
// R20: host holds data input low in streaming read until commanding.
// R21: streaming read delivers channels in turn, status when enabled.
// R22: host uses the same read command byte in continuous conversion.
// R23: other command bytes in streaming read are ignored.
`timescale 1ns/1ps

module adc_conversion_mode_control
	import adc_mode_pkg::*;
#(
	parameter int BASE_CYC = BASE_CONV_CYC,
	parameter int ENH27_CYC = SETTLE_27_CYC,
	parameter int ENH25_CYC = SETTLE_25_CYC,
	parameter int ENH20_CYC = SETTLE_20_CYC,
	parameter int ENH16_CYC = SETTLE_16_CYC
) (
	// master clock and reset
	input  wire logic                clk_in,
	input  wire logic                rst_b_in,
	// serial port
	input  wire logic                sclk_in,
	input  wire logic                cs_b_in,
	input  wire logic                din_in,
	output logic                     dout_out,
	output logic                     dout_oe_out,
	// configuration
	input  wire logic [CHAN_NUM-1:0] channel_enable_in,
	input  wire logic                status_append_in,
	input  wire logic                filter_type_in,
	input  wire logic                enhanced_en_in,
	input  wire logic [1:0]          enhanced_rate_in,
	input  wire logic                stream_read_enable_in,
	// modulator sample
	input  wire logic [SAMPLE_W-1:0] sample_in,
	// status
	output logic [STATUS_W-1:0]      status_out,
	output logic                     stream_active_out,
	output logic                     filter_mismatch_out
);

	function automatic logic [CHAN_W-1:0] next_chan(
		input logic [CHAN_W-1:0]   cur,
		input logic [CHAN_NUM-1:0] en);
		logic [CHAN_W-1:0] idx;
		logic [CHAN_W-1:0] res;
		logic              found;
		res = RST_CHAN;
		found = 1'b0;
		for (int i = 1; i <= CHAN_NUM; i++) begin
			idx = cur + CHAN_W'(i);
			if (!found && en[idx]) begin
				res = idx;
				found = 1'b1;
			end
		end
		return res;
	endfunction

	// R1 rate table
	function automatic logic [CONV_CNT_W-1:0] conv_period(
		input logic       enh,
		input logic [1:0] rate);
		logic [CONV_CNT_W-1:0] p;
		p = CONV_CNT_W'(BASE_CYC - 1);
		if (enh) begin
			case (rate)
				ENH_27SPS: p = CONV_CNT_W'(ENH27_CYC - 1);
				ENH_25SPS: p = CONV_CNT_W'(ENH25_CYC - 1);
				ENH_20SPS: p = CONV_CNT_W'(ENH20_CYC - 1);
				default:   p = CONV_CNT_W'(ENH16_CYC - 1);
			endcase
		end
		return p;
	endfunction

	// master clock domain state
	logic [CONV_CNT_W-1:0] conv_cnt;
	logic [CHAN_W-1:0]     chan;
	logic [WORD_W-1:0]     word;
	logic                  word_ext;
	logic                  rdy_b;
	logic                  stream_on;
	logic                  stream_req_d;
	logic [2:0]            read_sync, exit_sync, swr_sync;
	logic [1:0]            busy_sync;
	logic                  conv_done, pre_load, enh_ok, discard;
	logic                  read_evt, exit_evt, swr_evt;
	// serial clock domain state
	phase_type             phase;
	logic [BITCNT_W-1:0]   bit_cnt;
	logic [7:0]            cmd;
	logic [ONES_W-1:0]     ones_cnt;
	logic                  read_tog, exit_tog, swr_tog;
	logic [1:0]            rst_s, rdy_s, stream_s;
	logic                  sclk_rst_b, stream_l, rdy_l;
	logic                  stream_hold, frame_clr;
	logic [7:0]            next_cmd;
	logic [BITCNT_W-1:0]   last_bit;
	logic                  sending;

	// R3 postfilter needs sinc5+sinc1
	assign enh_ok = enhanced_en_in && (filter_type_in == FILT_SINC5_SINC1);
	assign filter_mismatch_out = enhanced_en_in && !enh_ok;
	assign conv_done = (conv_cnt == '0);
	assign pre_load = (conv_cnt == CONV_CNT_W'(PRE_LOAD_CYC));
	assign read_evt = read_sync[2] ^ read_sync[1];
	assign exit_evt = exit_sync[2] ^ exit_sync[1];
	assign swr_evt = swr_sync[2] ^ swr_sync[1];
	// R9 overrun during a read in plain mode
	assign discard = busy_sync[1] && !stream_on;
	// R12 status names the channel of the held result, not the next one
	assign status_out = {rdy_b, 3'h0, word[CHAN_W-1:0]};
	assign stream_active_out = stream_on;

	// crossings from the serial domain; stage 0 feeds only stage 1
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			read_sync <= '0;
			exit_sync <= '0;
			swr_sync <= '0;
			busy_sync <= '0;
		end else begin
			read_sync <= {read_sync[1:0], read_tog};
			exit_sync <= {exit_sync[1:0], exit_tog};
			swr_sync <= {swr_sync[1:0], swr_tog};
			busy_sync <= {busy_sync[0], phase == PH_DATA};
		end
	end

	// R4 free-running conversion timer
	always_ff @(posedge clk_in) begin
		if (!rst_b_in || swr_evt) begin
			conv_cnt <= conv_period(1'b0, ENH_27SPS);
		end else if (conv_done) begin
			conv_cnt <= conv_period(enh_ok, enhanced_rate_in);
		end else begin
			conv_cnt <= conv_cnt - 1'b1;
		end
	end

	// R10 channel sequencing, R21 same order when streaming
	always_ff @(posedge clk_in) begin
		if (!rst_b_in || swr_evt) begin
			chan <= RST_CHAN;
		end else if (conv_done) begin
			chan <= next_chan(chan, channel_enable_in);
		end
	end

	// R11 data update; word is quasi-static while the serial side reads it
	always_ff @(posedge clk_in) begin
		if (!rst_b_in || swr_evt) begin
			word <= '0;
			word_ext <= 1'b0;
		end else if (conv_done && channel_enable_in[chan] && !discard) begin
			// R12 status byte carries the channel, ready shown low
			word <= {sample_in, 1'b0, 3'h0, chan};
			word_ext <= status_append_in;
		end
	end

	// ready flag: completion wins over a read finishing in the same cycle
	always_ff @(posedge clk_in) begin
		if (!rst_b_in || swr_evt) begin
			rdy_b <= 1'b1;
		end else if (conv_done && channel_enable_in[chan] && !discard) begin
			// R5 ready bit low on completion
			rdy_b <= 1'b0;
		end else if (pre_load && stream_on) begin
			// R15 unread word dropped just before the next load
			rdy_b <= 1'b1;
		end else if (read_evt) begin
			// R8 R14 output high after a word read
			rdy_b <= 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			stream_on <= 1'b0;
			stream_req_d <= 1'b0;
		end else if (swr_evt) begin
			// a held enable level must not re-enter after a serial reset
			stream_on <= 1'b0;
			stream_req_d <= stream_read_enable_in;
		end else begin
			stream_req_d <= stream_read_enable_in;
			if (exit_evt) begin
				// R18 leave streaming read
				stream_on <= 1'b0;
			end else if (stream_read_enable_in && !stream_req_d) begin
				// R17 enter streaming read
				stream_on <= 1'b1;
			end
		end
	end

	// serial domain: reset and level crossings
	always_ff @(posedge sclk_in) begin
		rst_s <= {rst_s[0], rst_b_in};
		if (!sclk_rst_b) begin
			rdy_s <= 2'h3;
			stream_s <= '0;
		end else begin
			rdy_s <= {rdy_s[0], rdy_b};
			stream_s <= {stream_s[0], stream_on};
		end
	end

	assign sclk_rst_b = rst_s[1];
	assign stream_l = stream_s[1];
	assign rdy_l = rdy_s[1];
	// sclk is idle between frames, so a load cannot wait for serial edges
	assign stream_hold = stream_on && rdy_b;
	assign frame_clr = cs_b_in || stream_hold;
	assign next_cmd = {cmd[6:0], din_in};
	assign last_bit = (word_ext ? LEN_STATUS : LEN_PLAIN) - 1'b1;

	// command shift and ones count, cleared whenever chip select is high
	always_ff @(posedge sclk_in or posedge cs_b_in) begin
		if (cs_b_in) begin
			cmd <= '0;
			ones_cnt <= '0;
		end else begin
			cmd <= next_cmd;
			// R19 count consecutive ones on data input
			ones_cnt <= din_in ? ones_cnt + 1'b1 : '0;
		end
	end

	// R15 frame position restarts while no streaming word is pending
	always_ff @(posedge sclk_in or posedge frame_clr) begin
		if (frame_clr) begin
			phase <= PH_CMD;
			bit_cnt <= '0;
		end else begin
			if (stream_l) begin
				if (phase != PH_DONE) begin
					// R13 bits leave straight on the clocks
					bit_cnt <= bit_cnt + 1'b1;
					if (bit_cnt == last_bit) begin
						phase <= PH_DONE;
					end
				end
			end else if (phase == PH_CMD) begin
				bit_cnt <= bit_cnt + 1'b1;
				if (bit_cnt == CMD_LAST_BIT) begin
					bit_cnt <= '0;
					// R22 data read command opens the data phase
					if (next_cmd == CMD_READ_DATA) begin
						phase <= PH_DATA;
					end
				end
			end else if (phase == PH_DATA) begin
				bit_cnt <= bit_cnt + 1'b1;
				if (bit_cnt == last_bit) begin
					// R8 register may be read again
					phase <= PH_CMD;
					bit_cnt <= '0;
				end
			end
		end
	end

	// serial events, held across frames
	always_ff @(posedge sclk_in) begin
		if (!sclk_rst_b) begin
			read_tog <= 1'b0;
			exit_tog <= 1'b0;
			swr_tog <= 1'b0;
		end else begin
			if (!cs_b_in) begin
				if (bit_cnt == last_bit &&
				    ((stream_l && phase != PH_DONE) || phase == PH_DATA)) begin
					read_tog <= !read_tog;
				end
				// R18 R23 only the read command ends streaming
				if (stream_l && !rdy_l && bit_cnt == CMD_LAST_BIT &&
				    next_cmd == CMD_READ_DATA) begin
					exit_tog <= !exit_tog;
				end
				// R19 software reset after the 64th one
				if (din_in && ones_cnt == RESET_ONES_LAST) begin
					swr_tog <= !swr_tog;
				end
			end
		end
	end

	// R6 ready shows on the pin only while selected
	assign sending = stream_on ? (phase != PH_DONE && !rdy_b)
	                           : (phase == PH_DATA);
	assign dout_out = cs_b_in ? 1'b1
	                : (sending ? word[WORD_W-1-int'(bit_cnt)] : rdy_b);
	assign dout_oe_out = !cs_b_in;

	// R5 ready low after a kept completion
	a_ready_on_load: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		conv_done && channel_enable_in[chan] && !discard && !swr_evt
		|=> !rdy_b) else $error("ready not low after conversion");
	// R9 result dropped while a read is active
	a_overrun_drop: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		conv_done && discard && !swr_evt |=> $stable(word))
		else $error("word changed during a read");
	// R15 new result replaces an unread streaming word
	a_stream_replace: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		conv_done && stream_on && channel_enable_in[chan] && !swr_evt
		|=> word[WORD_W-1 -: SAMPLE_W] == $past(sample_in))
		else $error("streaming word not replaced");
	// R15 ready rises one cycle before the load
	a_preload_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		pre_load && stream_on && !swr_evt |=> rdy_b ##0 conv_done)
		else $error("no clear before streaming load");
	// R6 idle pin stays high
	a_pin_deselect: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		cs_b_in |-> dout_out && !dout_oe_out)
		else $error("pin driven low while deselected");
	// R8 read end raises ready
	a_read_raise: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		read_evt && !conv_done && !swr_evt |=> rdy_b)
		else $error("ready not high after read");
	// R10 sequencing lands on an enabled channel
	a_chan_order: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		conv_done && !swr_evt && $stable(channel_enable_in)
		&& (|channel_enable_in) |=> channel_enable_in[chan])
		else $error("disabled channel selected");
	// R12 status byte names the channel
	a_status_chan: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		conv_done && channel_enable_in[chan] && !discard && !swr_evt
		|=> word[CHAN_W-1:0] == $past(chan))
		else $error("status channel mismatch");
	// R18 exit command clears the mode
	a_stream_exit: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		exit_evt && !swr_evt |=> !stream_on [*2])
		else $error("streaming mode not left");
	// R19 software reset restores defaults
	a_soft_reset: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		swr_evt |=> rdy_b && !stream_on && chan == RST_CHAN)
		else $error("software reset incomplete");

	c_plain_read: cover property (@(posedge clk_in) disable iff (!rst_b_in)
		!stream_on && read_evt);
	c_stream_read: cover property (@(posedge clk_in) disable iff (!rst_b_in)
		stream_on && read_evt);
	c_overrun: cover property (@(posedge clk_in) disable iff (!rst_b_in)
		conv_done && discard);
	c_soft_reset: cover property (@(posedge clk_in) disable iff (!rst_b_in)
		swr_evt);

endmodule // adc_conversion_mode_control

// ### spi_host_model.sv
/*
 * Serial host model for the converter: frames, mode 3 bit shifting and
 * idle clocks for the reset synchroniser.
 * Assumes the device samples din and advances dout on sclk rising edges.
 */
`timescale 1ns/1ps

module spi_host_model (
	// serial port
	output logic      sclk_out,
	output logic      cs_b_out,
	output logic      din_out,
	input  wire logic dout_in
);
	// clock stands high outside frames apart from idle clocks, period 125 ns inside them
	initial begin
		sclk_out = 1'b1;
		cs_b_out = 1'b1;
		din_out = 1'b0;
	end

	task automatic frame(input logic on);
		cs_b_out = ~on;
		// a released line must not keep showing its last value
		if (!on) begin
			din_out = ~din_out;
		end
		#100;
	endtask

	// msb first, dout taken just before each rising edge
	task automatic shift(input logic [63:0] tx, input int n,
		output logic [31:0] rx);
		rx = 32'h0;
		for (int i = 0; i < n; i++) begin
			sclk_out = 1'b0;
			din_out = tx[n-1-i];
			#62.5;
			rx = {rx[30:0], dout_in};
			sclk_out = 1'b1;
			#62.5;
		end
	endtask

	// serial reset copy only moves on sclk edges
	task automatic idle_clocks(input int n);
		repeat (n) begin
			sclk_out = 1'b0;
			#62.5;
			sclk_out = 1'b1;
			#62.5;
		end
	endtask
endmodule // spi_host_model

// ### adc_conversion_mode_control_tb.sv
/*
 * Testbench for the conversion mode controller: plain and streaming
 * reads, channel order, overrun, exit and serial reset.
 * Assumes the shared package and the serial host model.
 */
`timescale 1ns/1ps

module adc_conversion_mode_control_tb;
	import adc_mode_pkg::*;
	localparam int PERIOD = 1000;
	localparam logic [CHAN_NUM-1:0] EN_MASK = 16'h8005;
	logic                clk_in;
	logic                rst_b_in;
	logic                sclk;
	logic                cs_b;
	logic                din;
	logic                dout_out;
	logic                dout_oe_out;
	logic [CHAN_NUM-1:0] channel_enable_in;
	logic                status_append_in;
	logic                filter_type_in;
	logic                enhanced_en_in;
	logic [1:0]          enhanced_rate_in;
	logic                stream_read_enable_in;
	logic [SAMPLE_W-1:0] sample_in;
	logic [STATUS_W-1:0] status_out;
	logic                stream_active_out;
	logic                filter_mismatch_out;
	logic [31:0]         rx;
	logic [31:0]         rx2;
	logic [CHAN_W-1:0]   ch;
	int                  errors = 0;
	int                  n_checks = 0;
	int                  cycles = 0;

	adc_conversion_mode_control #(.BASE_CYC(PERIOD)) dut_u (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .sclk_in(sclk),
		.cs_b_in(cs_b), .din_in(din), .dout_out(dout_out),
		.dout_oe_out(dout_oe_out), .channel_enable_in(channel_enable_in),
		.status_append_in(status_append_in), .filter_type_in(filter_type_in),
		.enhanced_en_in(enhanced_en_in), .enhanced_rate_in(enhanced_rate_in),
		.stream_read_enable_in(stream_read_enable_in),
		.sample_in(sample_in), .status_out(status_out),
		.stream_active_out(stream_active_out),
		.filter_mismatch_out(filter_mismatch_out));

	spi_host_model host_u (.sclk_out(sclk), .cs_b_out(cs_b), .din_out(din),
		.dout_in(dout_out));

	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	task automatic end_of_test;
		$display("Checks %0d, errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// budget is a few dozen conversion periods
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			$display("Error at %0t: run hung", $time);
			end_of_test();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	function automatic logic [CHAN_W-1:0] next_ch(input logic [CHAN_W-1:0] c);
		return (c == 4'h0) ? 4'h2 : (c == 4'h2) ? 4'hF : 4'h0;
	endfunction

	task automatic settle(input int n);
		repeat (n) @(posedge clk_in);
		@(negedge clk_in);
	endtask

	// sel 0 waits on the ready status bit, sel 1 on the pin
	task automatic wait_rdy(input logic sel);
		for (int i = 0; i < 3 * PERIOD; i++) begin
			@(negedge clk_in);
			if ((sel ? dout_out : status_out[STAT_RDY_BIT]) === 1'b0) begin
				return;
			end
		end
		check(1'b1, 1'b0, "ready never fell");
	endtask

	task automatic read_word(input int n, input logic rdy_b);
		host_u.frame(1'b1);
		check(dout_out, rdy_b, "ready on pin");
		check(dout_oe_out, 1'b1, "pin enable");
		host_u.shift(64'h44, 8, rx);
		host_u.shift(64'h0, n, rx);
		settle(5);
		check(dout_out, 1'b1, "pin high after read");
		host_u.frame(1'b0);
	endtask

	initial begin
		rst_b_in = 1'b0;
		channel_enable_in = EN_MASK;
		status_append_in = 1'b0;
		filter_type_in = FILT_SINC5_SINC1;
		enhanced_en_in = 1'b0;
		enhanced_rate_in = ENH_27SPS;
		stream_read_enable_in = 1'b0;
		sample_in = 24'h0;
		host_u.idle_clocks(4);
		@(posedge clk_in);
		rst_b_in <= 1'b1;
		host_u.idle_clocks(4);
		@(negedge clk_in);
		check(status_out, 8'h80, "reset status");
		check(stream_active_out, 1'b0, "reset stream");
		check(dout_out, 1'b1, "idle pin");
		for (int r = 0; r < 4; r++) begin
			@(posedge clk_in);
			enhanced_en_in <= 1'b1;
			enhanced_rate_in <= r[1:0];
			filter_type_in <= ~FILT_SINC5_SINC1;
			settle(1);
			check(filter_mismatch_out, 1'b1, "mismatch");
			filter_type_in <= FILT_SINC5_SINC1;
			settle(1);
			check(filter_mismatch_out, 1'b0, "match");
		end
		@(posedge clk_in);
		enhanced_en_in <= 1'b0;
		status_append_in <= 1'b1;
		ch = 4'h0;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_in);
			sample_in <= 24'hC30000 + 24'(k);
			wait_rdy(1'b0);
			check(status_out[3:0], ch, "channel order");
			read_word(32, 1'b0);
			check(rx, {24'hC30000 + 24'(k), 4'h0, ch}, "word");
			ch = next_ch(ch);
		end
		read_word(32, 1'b1);
		check(rx, {24'hC30003, 4'h0, 4'h0}, "reread");
		@(posedge clk_in);
		status_append_in <= 1'b0;
		sample_in <= 24'h123456;
		wait_rdy(1'b0);
		host_u.frame(1'b1);
		host_u.shift(64'h44, 8, rx);
		host_u.shift(64'h0, 8, rx2);
		@(posedge clk_in);
		sample_in <= 24'h654321;
		settle(PERIOD + 20);
		host_u.shift(64'h0, 16, rx);
		check({rx2[7:0], rx[15:0]}, 24'h123456, "overrun discard");
		host_u.frame(1'b0);
		@(posedge clk_in);
		status_append_in <= 1'b1;
		sample_in <= 24'h5A0F3C;
		stream_read_enable_in <= 1'b1;
		settle(2);
		check(stream_active_out, 1'b1, "stream entry");
		// the plain-mode word, already read, is replaced by the first streaming load
		settle(PERIOD + 20);
		host_u.frame(1'b1);
		for (int w = 0; w < 2; w++) begin
			wait_rdy(1'b1);
			host_u.shift(64'h0, 32, rx);
			check(rx[31:8], 24'h5A0F3C, "stream data");
			if (w == 0) begin
				check(EN_MASK[rx[3:0]], 1'b1, "enabled chan");
			end else begin
				check(rx[3:0], next_ch(ch), "stream chan");
			end
			ch = rx[3:0];
			settle(300);
			check(dout_out, 1'b1, "read once");
		end
		wait_rdy(1'b1);
		settle(PERIOD + 20);
		host_u.shift(64'h0, 32, rx);
		check(rx[3:0], next_ch(next_ch(ch)), "stale dropped");
		host_u.shift(64'h55, 8, rx);
		settle(5);
		check(stream_active_out, 1'b1, "other byte");
		host_u.frame(1'b0);
		host_u.frame(1'b1);
		wait_rdy(1'b1);
		host_u.shift(64'h44, 8, rx);
		settle(5);
		check(stream_active_out, 1'b0, "stream exit");
		host_u.frame(1'b0);
		@(posedge clk_in);
		stream_read_enable_in <= 1'b0;
		@(posedge clk_in);
		stream_read_enable_in <= 1'b1;
		host_u.frame(1'b1);
		host_u.shift({64{1'b1}}, 64, rx);
		host_u.frame(1'b0);
		settle(5);
		check(status_out, 8'h80, "soft reset status");
		check(stream_active_out, 1'b0, "soft reset stream");
		@(posedge clk_in);
		stream_read_enable_in <= 1'b0;
		channel_enable_in <= 16'h0040;
		wait_rdy(1'b0);
		check(status_out[3:0], 4'h6, "single channel");
		end_of_test();
	end
endmodule // adc_conversion_mode_control_tb
